/* inc/led_sink_params.svh */
`ifndef LED_SINK_PARAMS_SVH
`define LED_SINK_PARAMS_SVH
// channel geometry
`define CH_NUM 16
`define LEVEL_W 12
`define CORR_W 6
`define GRAY_LOAD_BITS 192
`define CORR_LOAD_BITS 96
// nonvolatile dot correction value before first programming
`define CORR_NV_DEFAULT 6'h3F
// last count of the grayscale counter
`define GRAY_CNT_LAST 12'hFFF
// register port
`define ADDR_W 8
`define DATA_W 32
`define REG_IRQ_STATUS 8'h00
`define REG_IRQ_MASK 8'h04
`define REG_LED_ERR 8'h08
`define REG_STATE 8'h0C
// interrupt bits
`define IRQ_W 4
`define IRQ_OPEN_LED 0
`define IRQ_OVERTEMP 1
`define IRQ_NV_WRITE 2
`define IRQ_LATCH 3
`define IRQ_MASK_RST 4'h0
// synchronised scalar pins
`define PIN_W 9
`endif

/* inc/led_sink_pkg.sv */
`include "led_sink_params.svh"
package led_sink_pkg;
  typedef enum logic {LOAD_GRAYSCALE = 1'b0, LOAD_DOT_CORR = 1'b1} load_mode_t;
  typedef logic [`ADDR_W-1:0] reg_addr_t;
  typedef logic [`DATA_W-1:0] reg_data_t;
endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  // two stages against metastability, a third only for edge finding
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edges are taken from the settled stages only
  assign level_o = sync_ff;
  assign rise_o = sync_ff & ~prev_ff;
  assign fall_o = ~sync_ff & prev_ff;
endmodule // pin_sync
`default_nettype wire

/* rtl/led_sink_driver_control.sv */
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "led_sink_params.svh"
// Contract
// - blanking high forces every channel output off
// - blanking high holds the grayscale counter at zero
// - blanking low lets grayscale PWM switch each channel
// - source select low uses nonvolatile store, high uses volatile register
// - nonvolatile store holds 3Fh per channel until programmed
// - mode input low loads grayscale, high loads dot correction
// - programming level with source select high copies register to store
// - grayscale counter advances only on the grayscale reference clock
// - latch strobe high copies shift register into register chosen by mode
// - latch strobe low keeps both registers unchanged
// - error output pulled low on open LED or overtemperature
// - serial data shifts in on serial pin and appears on serial out
// - one bit per shift clock rising edge, most significant first
// - load length 96 bits dot correction, 192 bits grayscale
// - open LED bits captured into status when latch strobe falls
module led_sink_driver_control (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic blank_i,
  input wire logic dot_correction_source_select_i,
  input wire logic mode_program_input_i,
  input wire logic prog_level_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_pin_i,
  input wire logic shift_latch_strobe_i,
  input wire logic grayscale_clk_i,
  input wire logic [`CH_NUM-1:0] open_led_detect_i,
  input wire logic overtemp_flag_i,
  input wire led_sink_pkg::reg_addr_t reg_addr_i,
  input wire led_sink_pkg::reg_data_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output led_sink_pkg::reg_data_t reg_rdata_o,
  output logic [`CH_NUM-1:0] channel_sink_output_o,
  output logic [`CH_NUM*`CORR_W-1:0] dot_correction_o,
  output logic serial_out_pin_o,
  output logic error_open_drain_out_o,
  output logic error_open_drain_out_oe_o,
  output logic irq_o
);
  import led_sink_pkg::*;

  // synchronised pin views
  logic [`PIN_W-1:0] pin_lvl;
  logic [`PIN_W-1:0] pin_rise;
  logic [`PIN_W-1:0] pin_fall;
  logic [`CH_NUM-1:0] open_led_lvl;
  logic blank;
  logic src_sel;
  logic mode_lvl;
  logic prog_lvl;
  logic shift_rise;
  logic sin_lvl;
  logic latch_lvl;
  logic latch_fall;
  logic gray_rise;
  logic overtemp_lvl;
  logic overtemp_rise;
  load_mode_t load_mode;

  // storage
  logic [`GRAY_LOAD_BITS-1:0] shift_ff;
  logic [`GRAY_LOAD_BITS-1:0] grayscale_level_ff;
  logic [`CORR_LOAD_BITS-1:0] dot_correction_reg_ff;
  logic [`CORR_LOAD_BITS-1:0] dot_correction_nv_ff;
  logic [`CORR_LOAD_BITS-1:0] dot_correction_ff;
  logic serial_out_ff;
  logic [`CH_NUM-1:0] led_err_ff;
  logic overtemp_info_ff;

  // pwm
  logic [`LEVEL_W-1:0] gray_cnt_ff;
  logic gray_done_ff;
  logic [`CH_NUM-1:0] nxt_chan_on;
  logic [`CH_NUM-1:0] chan_on_ff;

  // error and interrupt
  logic open_led_err;
  logic err_ff;
  logic open_led_prev_ff;
  logic nv_wr_req;
  logic nv_wr_prev_ff;
  logic [`IRQ_W-1:0] irq_event;
  logic [`IRQ_W-1:0] irq_status_ff;
  logic [`IRQ_W-1:0] nxt_irq_status;
  logic [`IRQ_W-1:0] irq_mask_ff;
  reg_data_t rdata_ff;
  reg_data_t nxt_rdata;

  // every pin from the host is foreign to ref_clk_i
  pin_sync #(
    .WIDTH(`PIN_W)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_i({blank_i, dot_correction_source_select_i, mode_program_input_i, prog_level_i,
            shift_clk_i, serial_in_pin_i, shift_latch_strobe_i, grayscale_clk_i,
            overtemp_flag_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // detector levels come from the analog side, also asynchronous
  pin_sync #(
    .WIDTH(`CH_NUM)
  ) u_open_led_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_i(open_led_detect_i),
    .level_o(open_led_lvl),
    .rise_o(),
    .fall_o()
  );

  // unpack the scalar pins
  assign blank = pin_lvl[8];
  assign src_sel = pin_lvl[7];
  assign mode_lvl = pin_lvl[6];
  assign prog_lvl = pin_lvl[5];
  assign shift_rise = pin_rise[4];
  assign sin_lvl = pin_lvl[3];
  assign latch_lvl = pin_lvl[2];
  assign latch_fall = pin_fall[2];
  assign gray_rise = pin_rise[1];
  assign overtemp_lvl = pin_lvl[0];
  assign overtemp_rise = pin_rise[0];
  // programming level counts as dot correction mode
  assign load_mode = (mode_lvl || prog_lvl) ? LOAD_DOT_CORR : LOAD_GRAYSCALE;

  // serial input shift register; data and clock share the same sync delay,
  // so the sampled bit is the one that stood at the shift clock edge
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      shift_ff <= '0;
    end
    else if (shift_rise)
    begin
      shift_ff <= {shift_ff[`GRAY_LOAD_BITS-2:0], sin_lvl};
    end
    else if (latch_fall && (load_mode == LOAD_GRAYSCALE))
    begin
      // status for readback enters the top of the chain
      shift_ff[`GRAY_LOAD_BITS-1 -: `CH_NUM] <= open_led_lvl;
      shift_ff[`GRAY_LOAD_BITS-`CH_NUM-1] <= overtemp_lvl;
    end
  end

  // serial out taps the end of the active load length, so cascades line up
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      serial_out_ff <= 1'b0;
    end
    else if (load_mode == LOAD_DOT_CORR)
    begin
      serial_out_ff <= shift_ff[`CORR_LOAD_BITS-1];
    end
    else
    begin
      serial_out_ff <= shift_ff[`GRAY_LOAD_BITS-1];
    end
  end

  // grayscale latch is transparent while the strobe is high; latching mid-cycle
  // changes the pwm at once, the host should latch at cycle end
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      grayscale_level_ff <= '0;
    end
    else if (latch_lvl && (load_mode == LOAD_GRAYSCALE))
    begin
      grayscale_level_ff <= shift_ff;
    end
  end

  // dot correction latch uses the low 96 bits, the last ones shifted
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      dot_correction_reg_ff <= '0;
    end
    else if (latch_lvl && (load_mode == LOAD_DOT_CORR))
    begin
      dot_correction_reg_ff <= shift_ff[`CORR_LOAD_BITS-1:0];
    end
  end

  // nonvolatile store; here a reset restores the unprogrammed value
  assign nv_wr_req = prog_lvl && src_sel;
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      dot_correction_nv_ff <= {`CH_NUM{`CORR_NV_DEFAULT}};
    end
    else if (nv_wr_req)
    begin
      dot_correction_nv_ff <= dot_correction_reg_ff;
    end
  end

  // active dot correction source
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      dot_correction_ff <= '0;
    end
    else if (src_sel)
    begin
      dot_correction_ff <= dot_correction_reg_ff;
    end
    else
    begin
      dot_correction_ff <= dot_correction_nv_ff;
    end
  end

  // grayscale counter stops after its last count until blanking restarts it
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i || blank)
    begin
      gray_cnt_ff <= '0;
      gray_done_ff <= 1'b0;
    end
    else if (gray_rise && !gray_done_ff)
    begin
      if (gray_cnt_ff == `GRAY_CNT_LAST)
      begin
        gray_done_ff <= 1'b1;
      end
      else
      begin
        gray_cnt_ff <= gray_cnt_ff + 1'b1;
      end
    end
  end

  // per channel compare against the stored level
  genvar ch;
  generate
    for (ch = 0; ch < `CH_NUM; ch++)
    begin : g_chan
      assign nxt_chan_on[ch] = !blank && !gray_done_ff
        && (gray_cnt_ff < grayscale_level_ff[ch*`LEVEL_W +: `LEVEL_W]);
    end
  endgenerate

  // outputs registered for glitch free sink switching
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      chan_on_ff <= '0;
    end
    else
    begin
      chan_on_ff <= nxt_chan_on;
    end
  end

  // open LED only counts on a driven channel and is masked by blanking
  assign open_led_err = !blank && |(open_led_lvl & chan_on_ff);
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      err_ff <= 1'b0;
      open_led_prev_ff <= 1'b0;
    end
    else
    begin
      err_ff <= open_led_err || overtemp_lvl;
      open_led_prev_ff <= open_led_err;
    end
  end

  // status information captured on the falling latch strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      led_err_ff <= '0;
      overtemp_info_ff <= 1'b0;
    end
    else if (latch_fall)
    begin
      led_err_ff <= open_led_lvl;
      overtemp_info_ff <= overtemp_lvl;
    end
  end

  // edge of the store write request
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      nv_wr_prev_ff <= 1'b0;
    end
    else
    begin
      nv_wr_prev_ff <= nv_wr_req;
    end
  end

  // events; a read clear never swallows an event of the same cycle
  always_comb
  begin
    irq_event = '0;
    irq_event[`IRQ_OPEN_LED] = open_led_err && !open_led_prev_ff;
    irq_event[`IRQ_OVERTEMP] = overtemp_rise;
    irq_event[`IRQ_NV_WRITE] = nv_wr_req && !nv_wr_prev_ff;
    irq_event[`IRQ_LATCH] = latch_fall;
    nxt_irq_status = irq_status_ff;
    if (reg_rd_i && (reg_addr_i == `REG_IRQ_STATUS))
    begin
      nxt_irq_status = '0;
    end
    nxt_irq_status = nxt_irq_status | irq_event;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      irq_status_ff <= '0;
    end
    else
    begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  // mask is the only writable register
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      irq_mask_ff <= `IRQ_MASK_RST;
    end
    else if (reg_wr_i && (reg_addr_i == `REG_IRQ_MASK))
    begin
      irq_mask_ff <= reg_wdata_i[`IRQ_W-1:0];
    end
  end

  // read mux; unmapped addresses read zero, data stands one cycle only
  always_comb
  begin
    nxt_rdata = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `REG_IRQ_STATUS: nxt_rdata = {{(`DATA_W-`IRQ_W){1'b0}}, irq_status_ff};
        `REG_IRQ_MASK: nxt_rdata = {{(`DATA_W-`IRQ_W){1'b0}}, irq_mask_ff};
        `REG_LED_ERR: nxt_rdata = {{(`DATA_W-`CH_NUM-1){1'b0}}, overtemp_info_ff, led_err_ff};
        `REG_STATE: nxt_rdata = {{(`DATA_W-`LEVEL_W-5){1'b0}}, gray_done_ff, blank,
                                 load_mode, src_sel, prog_lvl, gray_cnt_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // drive the pins
  assign reg_rdata_o = rdata_ff;
  assign channel_sink_output_o = chan_on_ff;
  assign dot_correction_o = dot_correction_ff;
  assign serial_out_pin_o = serial_out_ff;
  // open drain: only ever pulls low
  assign error_open_drain_out_o = 1'b0;
  assign error_open_drain_out_oe_o = err_ff;
  assign irq_o = |(irq_status_ff & irq_mask_ff);
endmodule // led_sink_driver_control
`default_nettype wire

/* verif/led_sink_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "led_sink_params.svh"
module led_sink_monitor (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic blank_i,
  input wire logic dot_correction_source_select_i,
  input wire logic mode_program_input_i,
  input wire logic shift_clk_i,
  input wire logic shift_latch_strobe_i,
  input wire logic [`CH_NUM-1:0] open_led_detect_i,
  input wire logic overtemp_flag_i,
  input wire logic [`CH_NUM-1:0] channel_sink_output_o,
  input wire logic [`CH_NUM*`CORR_W-1:0] dot_correction_o,
  input wire logic serial_out_pin_o,
  input wire logic error_open_drain_out_o,
  input wire logic error_open_drain_out_oe_o
);
  // pins pass a two-flop sync, so each check except a_pin_never_high waits a few cycles of steady input
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_blank_forces_off: assert property (blank_i [*4] |=> channel_sink_output_o == '0)
    else $error("channel on while blanked");
  a_pin_never_high: assert property (error_open_drain_out_o == 1'b0)
    else $error("error pin driven high");
  a_hot_pulls_low: assert property (overtemp_flag_i [*4] |=> error_open_drain_out_oe_o)
    else $error("overtemp not reported");
  a_quiet_releases: assert property ((!overtemp_flag_i && open_led_detect_i == '0) [*4]
    |=> !error_open_drain_out_oe_o) else $error("error without cause");
  a_blank_masks_led: assert property ((blank_i && !overtemp_flag_i) [*4]
    |=> !error_open_drain_out_oe_o) else $error("open led seen while blanked");
  a_store_kept: assert property (!dot_correction_source_select_i [*4]
    |=> $stable(dot_correction_o)) else $error("store value moved");
  a_latch_holds: assert property ((dot_correction_source_select_i && !shift_latch_strobe_i) [*4]
    |=> $stable(dot_correction_o)) else $error("register moved without strobe");
  a_serial_out_pin_holds: assert property (($stable(shift_clk_i) && !shift_latch_strobe_i
    && $stable(mode_program_input_i)) [*6] |=> $stable(serial_out_pin_o))
    else $error("serial out moved without shift");
endmodule // led_sink_monitor
bind led_sink_driver_control led_sink_monitor u_led_sink_monitor (.*);
`default_nettype wire

/* verif/serial_host.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_host (
  output logic shift_clk_o,
  output logic serial_data_o,
  output logic latch_o,
  output logic gray_clk_o
);
  // link clock stands low between frames
  initial
  begin
    shift_clk_o = 1'b0;
    serial_data_o = 1'b0;
    latch_o = 1'b0;
    gray_clk_o = 1'b0;
  end
  // low n bits, msb first, 125 ns link period
  task automatic send(input logic [191:0] d, input int n);
    // step off the system clock edge so no pin moves while it is sampled
    #1;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data_o = d[i];
      #62.5 shift_clk_o = 1'b1;
      #62.5 shift_clk_o = 1'b0;
    end
    serial_data_o = ~serial_data_o; // released line must not show a stale bit
  endtask
  // high then low, so the device latches and then captures status
  task automatic latch();
    #1;
    #100 latch_o = 1'b1;
    #100 latch_o = 1'b0;
    #100;
  endtask
  // grayscale clock is separate from the shift clock
  task automatic gray_pulse();
    #1;
    #40 gray_clk_o = 1'b1;
    #40 gray_clk_o = 1'b0;
  endtask
endmodule // serial_host
`default_nettype wire

/* verif/led_sink_driver_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "led_sink_params.svh"
`define CHK(nm, e, s) n_compared++; if ((s) !== (e)) begin $display("BAD %s exp %h seen %h", nm, e, s); bad_count++; end
module led_sink_driver_control_tb;
  import led_sink_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic blank = 1'b1;
  logic src_sel = 1'b0;
  logic mode = 1'b0;
  logic prog = 1'b0;
  logic hot = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] open_led = '0;
  reg_addr_t addr = '0;
  reg_data_t wdata = '0;
  reg_data_t rdata;
  wire reg_data_t rdata_w;
  wire sclk, sdata, strobe, gclk, serial_out_pin, err, err_oe, irq;
  wire [15:0] chan;
  wire [95:0] dc;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [3:0] lvl [16];
  logic [191:0] gs_word, dc1, dc2;

  always #5 ref_clk_i = ~ref_clk_i;

  serial_host u_serial_host (.shift_clk_o(sclk), .serial_data_o(sdata), .latch_o(strobe),
    .gray_clk_o(gclk));
  led_sink_driver_control u_led_sink_driver_control (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .blank_i(blank), .dot_correction_source_select_i(src_sel), .mode_program_input_i(mode),
    .prog_level_i(prog), .shift_clk_i(sclk), .serial_in_pin_i(sdata),
    .shift_latch_strobe_i(strobe), .grayscale_clk_i(gclk), .open_led_detect_i(open_led),
    .overtemp_flag_i(hot), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata_w), .channel_sink_output_o(chan), .dot_correction_o(dc),
    .serial_out_pin_o(serial_out_pin), .error_open_drain_out_o(err), .error_open_drain_out_oe_o(err_oe),
    .irq_o(irq));

  // channel n is on while the count is below its level
  function automatic logic [15:0] exp_on(int k);
    for (int n = 0; n < 16; n++) exp_on[n] = (lvl[n] > k);
  endfunction

  task automatic wt(int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // read data is taken in the one cycle where it stands
  task automatic rd_reg(input reg_addr_t a, output reg_data_t d);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 d = rdata_w;
  endtask

  task automatic wr_reg(input reg_addr_t a, input reg_data_t d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic complete_run();
    $display("compared %0d, bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // a hang counts as a failure
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    void'($urandom(32'h52E2));
    for (int n = 0; n < 16; n++) lvl[n] = (n == 0) ? 4'h0 : 4'(1 + $urandom % 5);
    dc1 = 192'({$urandom, $urandom, $urandom});
    dc2 = 192'({$urandom, $urandom, $urandom});
    for (int n = 0; n < 16; n++) gs_word[12*n +: 12] = 12'(lvl[n]);
    wt(1);
    @(posedge ref_clk_i) nrst_i <= 1'b1;
    wt(4);
    `CHK("dc store", {16{6'h3F}}, dc)
    @(posedge ref_clk_i) mode <= 1'b1;
    u_serial_host.send(dc1, 96);
    u_serial_host.latch();
    @(posedge ref_clk_i) src_sel <= 1'b1;
    wt(5);
    `CHK("dc reg", dc1[95:0], dc)
    u_serial_host.send(dc2, 96);
    wt(6);
    `CHK("dc held", dc1[95:0], dc)
    `CHK("serial_out_pin", dc2[95], serial_out_pin)
    @(posedge ref_clk_i) prog <= 1'b1;
    wt(5);
    @(posedge ref_clk_i) prog <= 1'b0;
    wt(3);
    @(posedge ref_clk_i) src_sel <= 1'b0;
    wt(5);
    `CHK("dc stored", dc1[95:0], dc)
    @(posedge ref_clk_i) mode <= 1'b0;
    u_serial_host.send(gs_word, 192);
    u_serial_host.latch();
    wt(4);
    `CHK("blanked", 16'h0, chan)
    @(posedge ref_clk_i) blank <= 1'b0;
    wt(6);
    `CHK("pwm start", exp_on(0), chan)
    for (int k = 1; k < 7; k++)
    begin
      u_serial_host.gray_pulse();
      wt(6);
      `CHK("pwm step", exp_on(k), chan)
    end
    // six grayscale clock pulses leave the count at six
    rd_reg(`REG_STATE, rdata);
    `CHK("state", 32'h6, rdata)
    @(posedge ref_clk_i) blank <= 1'b1;
    wt(4);
    @(posedge ref_clk_i) blank <= 1'b0;
    wt(6);
    `CHK("restart", exp_on(0), chan)
    `CHK("err idle", 1'b0, err_oe)
    @(posedge ref_clk_i) open_led <= 16'h0002;
    wt(5);
    `CHK("err led", 1'b1, err_oe)
    `CHK("irq masked", 1'b0, irq)
    u_serial_host.latch();
    rd_reg(`REG_LED_ERR, rdata);
    `CHK("led info", 32'h2, rdata)
    wr_reg(`REG_IRQ_MASK, 32'h1);
    wt(2);
    `CHK("irq on", 1'b1, irq)
    rd_reg(`REG_IRQ_STATUS, rdata);
    `CHK("status", 32'hD, rdata)
    wt(2);
    `CHK("irq clear", 1'b0, irq)
    rd_reg(8'h10, rdata);
    `CHK("unmapped", 32'h0, rdata)
    @(posedge ref_clk_i) hot <= 1'b1;
    @(posedge ref_clk_i) open_led <= '0;
    wt(5);
    `CHK("err hot", 1'b1, err_oe)
    rd_reg(`REG_IRQ_STATUS, rdata);
    `CHK("status hot", 32'h2, rdata)
    @(posedge ref_clk_i) hot <= 1'b0;
    wt(5);
    `CHK("err off", 1'b0, err_oe)
    `CHK("pin low", 1'b0, err)
    complete_run();
  end
endmodule // led_sink_driver_control_tb
`default_nettype wire
